// ===== include/fxe_pkg.sv
package fxe_pkg;

  // register byte addresses (byte address = 4 * word index)
  localparam logic [11:0] FXE_A_FILE_SEL   = 12'h000;
  localparam logic [11:0] FXE_A_OPEN_MODE  = 12'h004;
  localparam logic [11:0] FXE_A_OP_SEL     = 12'h008;
  localparam logic [11:0] FXE_A_EXECUTE    = 12'h00C;
  localparam logic [11:0] FXE_A_STATUS     = 12'h010;
  localparam logic [11:0] FXE_A_RESULT     = 12'h014;
  localparam logic [11:0] FXE_A_FILE_SIZE  = 12'h018;
  localparam logic [11:0] FXE_A_OFFSET     = 12'h01C;
  localparam logic [11:0] FXE_A_LENGTH     = 12'h020;
  localparam logic [11:0] FXE_A_BUF_LEN    = 12'h024;
  localparam logic [11:0] FXE_A_IRQ_STAT   = 12'h028;
  localparam logic [11:0] FXE_A_IRQ_EN     = 12'h02C;
  localparam logic [11:0] FXE_A_IRQ_CLR    = 12'h030;
  // buffer window: byte i at FXE_A_BUF_BASE + 4*i
  localparam logic [11:0] FXE_A_BUF_BASE   = 12'h040;
  localparam logic [11:0] FXE_A_BUF_END    = 12'hFB0;

  localparam int FXE_BUF_BYTES = 988;

  // operation codes
  localparam logic [1:0] FXE_OP_OPEN  = 2'h0;
  localparam logic [1:0] FXE_OP_CLOSE = 2'h1;
  localparam logic [1:0] FXE_OP_READ  = 2'h2;
  localparam logic [1:0] FXE_OP_WRITE = 2'h3;

  localparam logic FXE_MODE_READ  = 1'b0;
  localparam logic FXE_MODE_WRITE = 1'b1;

  // status codes
  localparam logic [2:0] FXE_ST_SUCCESS       = 3'h0;
  localparam logic [2:0] FXE_ST_INVALID_PARAM = 3'h1;
  localparam logic [2:0] FXE_ST_READ_ONLY     = 3'h2;
  localparam logic [2:0] FXE_ST_NOT_OPENED    = 3'h3;
  localparam logic [2:0] FXE_ST_TOO_BIG       = 3'h4;
  localparam logic [2:0] FXE_ST_FILE_INVALID  = 3'h5;

  // interrupt status bits
  localparam int FXE_IRQ_DONE = 0;
  localparam int FXE_IRQ_ERR  = 1;

  typedef enum logic [2:0] {
    FXE_IDLE  = 3'b000,
    FXE_CHECK = 3'b001,
    FXE_MOVE  = 3'b010,
    FXE_WAIT  = 3'b011,
    FXE_DONE  = 3'b100
  } fxe_state_t;

endpackage

// ===== rtl/fxe_engine.sv
// What this block does
// - writing 1 to execute starts the operation; reads nonzero until done
// - status holds zero on success, else an error code, after every operation
// - buffer holds 988 bytes, shown as buffer length, limits each operation
// - opened for read, file size shows bytes the file holds
// - opened for write, file size shows most bytes the file accepts
// - read copies bytes from file offset into buffer, reports count read
// - write stores buffer at file offset, reports count written
// - write to a read-only file fails with read-only error
// - read, write or close on an unopened file fails with not-opened error
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module fxe_engine
  import fxe_pkg::*;
#(
  parameter int NUM_FILES = 8,
  parameter int SIZE_W = 24,
  parameter int SADDR_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // file storage information per selected file
  output logic [$clog2(NUM_FILES)-1:0] store_file,
  input wire logic store_present,
  input wire logic store_read_only,
  input wire logic [SIZE_W-1:0] store_cur_size,
  input wire logic [SIZE_W-1:0] store_max_size,
  // byte port to file storage, one byte per request
  output logic store_req,
  output logic store_we,
  output logic [SADDR_W-1:0] store_addr,
  output logic [7:0] store_wdata,
  input wire logic store_ack,
  input wire logic [7:0] store_rdata,
  // interrupt
  output logic irq
);

  localparam int FW = $clog2(NUM_FILES);
  localparam int BW = $clog2(FXE_BUF_BYTES);

  fxe_state_t state_q;
  logic [FW-1:0] file_sel_q;
  logic mode_q;
  logic [1:0] op_q;
  logic [2:0] status_q;
  logic [SIZE_W-1:0] result_q;
  logic [SIZE_W-1:0] size_q;
  logic [SIZE_W-1:0] offset_q;
  logic [SIZE_W-1:0] length_q;
  logic [NUM_FILES-1:0] opened_q;
  logic [NUM_FILES-1:0] open_wr_q;
  logic [SIZE_W-1:0] count_q;
  logic [SIZE_W-1:0] limit_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [7:0] buf_mem [FXE_BUF_BYTES];
  logic [7:0] buf_rd;

  // one open flag per file entry, any number open at once; the open-mode is kept per file
  logic busy;
  logic start;
  logic buf_hit;
  logic [BW-1:0] buf_idx;
  logic done_evt;
  logic [SIZE_W-1:0] end_pos;
  logic [SIZE_W-1:0] eff_len;

  assign busy = (state_q != FXE_IDLE);
  assign start = reg_wr && reg_addr == FXE_A_EXECUTE && reg_wdata[0] &&
                 !busy;
  assign buf_hit = reg_addr >= FXE_A_BUF_BASE && reg_addr < FXE_A_BUF_END &&
                   reg_addr[1:0] == 2'h0;
  assign buf_idx = BW'((reg_addr - FXE_A_BUF_BASE) >> 2);
  assign done_evt = (state_q == FXE_DONE);
  assign end_pos = offset_q + length_q;
  // the buffer bounds each single operation
  assign eff_len = (length_q > SIZE_W'(FXE_BUF_BYTES)) ?
                   SIZE_W'(FXE_BUF_BYTES) : length_q;

  // configuration registers; locked while an operation runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_sel_q <= '0;
      mode_q <= FXE_MODE_READ;
      op_q <= FXE_OP_OPEN;
      offset_q <= '0;
      length_q <= '0;
    end else if (reg_wr && !busy) begin
      if (reg_addr == FXE_A_FILE_SEL) begin
        file_sel_q <= reg_wdata[FW-1:0];
      end else if (reg_addr == FXE_A_OPEN_MODE) begin
        mode_q <= reg_wdata[0];
      end else if (reg_addr == FXE_A_OP_SEL) begin
        op_q <= reg_wdata[1:0];
      end else if (reg_addr == FXE_A_OFFSET) begin
        offset_q <= reg_wdata[SIZE_W-1:0];
      end else if (reg_addr == FXE_A_LENGTH) begin
        length_q <= reg_wdata[SIZE_W-1:0];
      end
    end
  end

  // operation sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FXE_IDLE;
      status_q <= FXE_ST_SUCCESS;
      result_q <= '0;
      count_q <= '0;
      limit_q <= '0;
    end else begin
      case (state_q)
        FXE_IDLE: begin
          if (start) begin
            state_q <= FXE_CHECK;
          end
        end
        FXE_CHECK: begin
          count_q <= '0;
          limit_q <= eff_len;
          state_q <= FXE_DONE;
          result_q <= '0;
          if (!store_present) begin
            status_q <= FXE_ST_FILE_INVALID;
          end else if (op_q != FXE_OP_OPEN && !opened_q[file_sel_q]) begin
            status_q <= FXE_ST_NOT_OPENED;
          end else if (op_q == FXE_OP_WRITE &&
                       (store_read_only || !open_wr_q[file_sel_q])) begin
            status_q <= FXE_ST_READ_ONLY;
          end else if (op_q == FXE_OP_OPEN &&
                       mode_q == FXE_MODE_WRITE && store_read_only) begin
            status_q <= FXE_ST_READ_ONLY;
          end else if ((op_q == FXE_OP_READ || op_q == FXE_OP_WRITE) &&
                       (length_q > SIZE_W'(FXE_BUF_BYTES) ||
                        length_q == '0)) begin
            status_q <= FXE_ST_INVALID_PARAM;
          end else if (op_q == FXE_OP_WRITE && end_pos > store_max_size) begin
            status_q <= FXE_ST_TOO_BIG;
          end else begin
            status_q <= FXE_ST_SUCCESS;
            if (op_q == FXE_OP_READ) begin
              // a read past the end returns only what the file holds
              if (offset_q >= store_cur_size) begin
                limit_q <= '0;
              end else if (end_pos > store_cur_size) begin
                limit_q <= store_cur_size - offset_q;
              end
              state_q <= FXE_MOVE;
            end else if (op_q == FXE_OP_WRITE) begin
              state_q <= FXE_MOVE;
            end
          end
        end
        FXE_MOVE: begin
          if (count_q == limit_q) begin
            result_q <= count_q;
            state_q <= FXE_DONE;
          end else begin
            state_q <= FXE_WAIT;
          end
        end
        FXE_WAIT: begin
          if (store_ack) begin
            count_q <= count_q + 1'b1;
            state_q <= FXE_MOVE;
          end
        end
        FXE_DONE: begin
          state_q <= FXE_IDLE;
        end
        default: begin
          state_q <= FXE_IDLE;
        end
      endcase
    end
  end

  // open-file bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opened_q <= '0;
      open_wr_q <= '0;
    end else if (state_q == FXE_CHECK && store_present) begin
      if (op_q == FXE_OP_OPEN &&
          !(mode_q == FXE_MODE_WRITE && store_read_only)) begin
        opened_q[file_sel_q] <= 1'b1;
        open_wr_q[file_sel_q] <= mode_q;
      end else if (op_q == FXE_OP_CLOSE && opened_q[file_sel_q]) begin
        opened_q[file_sel_q] <= 1'b0;
        open_wr_q[file_sel_q] <= 1'b0;
      end
    end
  end

  // size shown depends on how the file was opened
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      size_q <= '0;
    end else if (state_q == FXE_CHECK && op_q == FXE_OP_OPEN &&
                 store_present) begin
      if (mode_q == FXE_MODE_WRITE) begin
        size_q <= store_max_size;
      end else begin
        size_q <= store_cur_size;
      end
    end
  end

  // storage byte port, one outstanding request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_req <= 1'b0;
      store_we <= 1'b0;
      store_addr <= '0;
      store_wdata <= 8'h00;
      store_file <= '0;
    end else begin
      store_file <= file_sel_q;
      if (state_q == FXE_MOVE && count_q != limit_q) begin
        store_req <= 1'b1;
        store_we <= (op_q == FXE_OP_WRITE);
        store_addr <= SADDR_W'(offset_q + count_q);
        store_wdata <= buf_mem[BW'(count_q)];
      end else if (store_ack) begin
        store_req <= 1'b0;
      end
    end
  end

  // transfer buffer: storage fills on reads, software on writes
  always_ff @(posedge clk) begin
    if (state_q == FXE_WAIT && store_ack && op_q == FXE_OP_READ) begin
      buf_mem[BW'(count_q)] <= store_rdata;
    end else if (reg_wr && buf_hit && !busy) begin
      buf_mem[buf_idx] <= reg_wdata[7:0];
    end
  end

  // buffer read is combinational; the output flop follows
  assign buf_rd = buf_mem[buf_idx];

  // interrupt enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= 2'h0;
    end else if (reg_wr && reg_addr == FXE_A_IRQ_EN) begin
      irq_en_q <= reg_wdata[1:0];
    end
  end

  // one sticky flag per event; a new event wins over a clear
  for (genvar g = 0; g < 2; g++) begin : g_irq
    logic ev_set;
    logic ev_clr;
    // the error flag only follows a failed operation
    assign ev_set = done_evt &&
                    (g == FXE_IRQ_DONE || status_q != FXE_ST_SUCCESS);
    assign ev_clr = reg_wr && reg_addr == FXE_A_IRQ_CLR && reg_wdata[g];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        irq_stat_q[g] <= 1'b0;
      end else if (ev_set) begin
        irq_stat_q[g] <= 1'b1;
      end else if (ev_clr) begin
        irq_stat_q[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // read data, one cycle after the strobe
  logic [31:0] rd_reg_d;
  always_comb begin
    rd_reg_d = 32'h0;
    if (reg_addr == FXE_A_FILE_SEL) begin
      rd_reg_d = 32'(file_sel_q);
    end else if (reg_addr == FXE_A_OPEN_MODE) begin
      rd_reg_d = 32'(mode_q);
    end else if (reg_addr == FXE_A_OP_SEL) begin
      rd_reg_d = 32'(op_q);
    end else if (reg_addr == FXE_A_EXECUTE) begin
      rd_reg_d = 32'(busy);
    end else if (reg_addr == FXE_A_STATUS) begin
      rd_reg_d = 32'(status_q);
    end else if (reg_addr == FXE_A_RESULT) begin
      rd_reg_d = 32'(result_q);
    end else if (reg_addr == FXE_A_FILE_SIZE) begin
      rd_reg_d = 32'(size_q);
    end else if (reg_addr == FXE_A_OFFSET) begin
      rd_reg_d = 32'(offset_q);
    end else if (reg_addr == FXE_A_LENGTH) begin
      rd_reg_d = 32'(length_q);
    end else if (reg_addr == FXE_A_BUF_LEN) begin
      rd_reg_d = 32'(FXE_BUF_BYTES);
    end else if (reg_addr == FXE_A_IRQ_STAT) begin
      rd_reg_d = 32'(irq_stat_q);
    end else if (reg_addr == FXE_A_IRQ_EN) begin
      rd_reg_d = 32'(irq_en_q);
    end else begin
      rd_reg_d = 32'h0;
    end
  end

  // data holds until the next read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (buf_hit) begin
        reg_rdata <= {24'h0, buf_rd};
      end else begin
        reg_rdata <= rd_reg_d;
      end
    end
  end

endmodule

// ===== sim/fxe_store_model.sv
`timescale 1ns/10ps
module fxe_store_model #(
  parameter int NUM_FILES = 8,
  parameter int SIZE_W = 24,
  parameter int SADDR_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // facts about the selected file
  input wire logic [$clog2(NUM_FILES)-1:0] store_file,
  output logic store_present,
  output logic store_read_only,
  output logic [SIZE_W-1:0] store_cur_size,
  output logic [SIZE_W-1:0] store_max_size,
  // byte port
  input wire logic store_req,
  input wire logic store_we,
  input wire logic [SADDR_W-1:0] store_addr,
  input wire logic [7:0] store_wdata,
  output logic store_ack,
  output logic [7:0] store_rdata
);
  logic [7:0] mem [NUM_FILES*64];
  logic [7:0] rd_q;
  logic [1:0] wait_q;
  int idx;
  // file 0 absent, file 3 read-only, sizes grow with index
  assign store_present = store_file != 0;
  assign store_read_only = store_file == 3;
  assign store_cur_size = SIZE_W'(store_file * 16 + 8);
  assign store_max_size = SIZE_W'(store_file * 32 + 64);
  // outside ack the line shows the inverse, never a stale byte
  assign store_rdata = store_ack ? rd_q : ~rd_q;
  assign idx = store_file * 64 + int'(store_addr[5:0]);
  initial begin
    for (int i = 0; i < NUM_FILES * 64; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // random wait of 0..3 cycles, so both prompt and slow answers occur
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_ack <= 1'b0;
      wait_q <= 2'h0;
      rd_q <= 8'h00;
    end else begin
      store_ack <= 1'b0;
      if (store_req && !store_ack && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (store_req && !store_ack) begin
        store_ack <= 1'b1;
        wait_q <= 2'($urandom_range(3, 0));
        rd_q <= mem[idx];
        if (store_we) begin
          mem[idx] <= store_wdata;
        end
      end
    end
  end
endmodule

// ===== sim/fxe_engine_asserts.sv
`timescale 1ns/10ps
module fxe_engine_chk
  import fxe_pkg::*;
#(
  parameter int NUM_FILES = 8,
  parameter int SIZE_W = 24,
  parameter int SADDR_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // storage port
  input wire logic [$clog2(NUM_FILES)-1:0] store_file,
  input wire logic store_present,
  input wire logic store_read_only,
  input wire logic [SIZE_W-1:0] store_cur_size,
  input wire logic [SIZE_W-1:0] store_max_size,
  input wire logic store_req,
  input wire logic store_we,
  input wire logic [SADDR_W-1:0] store_addr,
  input wire logic [7:0] store_wdata,
  input wire logic store_ack,
  input wire logic [7:0] store_rdata,
  // interrupt
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic sel_wr;
  assign sel_wr = reg_wr && reg_addr == FXE_A_FILE_SEL;
  sequence s_go;
    reg_wr && reg_addr == FXE_A_EXECUTE && reg_wdata[0];
  endsequence
  sequence s_poll;
    reg_rd && reg_addr == FXE_A_EXECUTE;
  endsequence
  a_exec_busy_rd: assert property (s_go ##1 s_poll |=>
    reg_rdata != 32'h0) else $error("execute read zero while busy");
  a_buf_len_rd: assert property (reg_rd && reg_addr == FXE_A_BUF_LEN
    |=> reg_rdata == 32'(FXE_BUF_BYTES)) else $error("bad buffer length");
  a_req_hold: assert property (store_req && !store_ack |=> store_req
    && $stable(store_addr) && $stable(store_we) && $stable(store_wdata))
    else $error("storage request changed before ack");
  a_ack_drop: assert property (store_ack |=> !store_req)
    else $error("request still up after ack");
  a_file_follow: assert property ($changed(store_file) |->
    $past(sel_wr) || $past(sel_wr, 2)) else $error("file index moved");
  a_ro_no_wr: assert property (store_req && store_we |->
    !store_read_only) else $error("write to read-only file");
  a_present_req: assert property (store_req |-> store_present)
    else $error("storage access to absent file");
  a_wr_in_max: assert property (store_req && store_we |->
    store_addr < store_max_size) else $error("write beyond permitted size");
endmodule
bind fxe_engine fxe_engine_chk #(.NUM_FILES(NUM_FILES), .SIZE_W(SIZE_W),
  .SADDR_W(SADDR_W)) u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .store_file(store_file),
  .store_present(store_present), .store_read_only(store_read_only),
  .store_cur_size(store_cur_size), .store_max_size(store_max_size),
  .store_req(store_req), .store_we(store_we), .store_addr(store_addr),
  .store_wdata(store_wdata), .store_ack(store_ack),
  .store_rdata(store_rdata), .irq(irq));

// ===== sim/fxe_engine_tb.sv
`timescale 1ns/10ps
module fxe_engine_tb;
  import fxe_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, want, irq, store_ack;
  logic want_q = 1'b0;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, v;
  logic [2:0] store_file;
  logic store_present, store_read_only, store_req, store_we;
  logic [23:0] store_cur_size, store_max_size, store_addr;
  logic [7:0] store_wdata, store_rdata;
  logic [7:0] d [3];
  int n_fail, compares, cyc;
  string nq[$];
  logic [31:0] eq[$];
  fxe_engine dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .store_file(store_file),
    .store_present(store_present), .store_read_only(store_read_only),
    .store_cur_size(store_cur_size), .store_max_size(store_max_size),
    .store_req(store_req), .store_we(store_we), .store_addr(store_addr),
    .store_wdata(store_wdata), .store_ack(store_ack),
    .store_rdata(store_rdata), .irq(irq));
  fxe_store_model u_store (.clk(clk), .rst_n(rst_n),
    .store_file(store_file), .store_present(store_present),
    .store_read_only(store_read_only), .store_cur_size(store_cur_size),
    .store_max_size(store_max_size), .store_req(store_req),
    .store_we(store_we), .store_addr(store_addr),
    .store_wdata(store_wdata), .store_ack(store_ack),
    .store_rdata(store_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic strobe(input logic [11:0] a, input logic w);
    reg_addr <= a;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
  endtask
  task automatic gap;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    reg_wdata <= w;
    strobe(a, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string n);
    nq.push_back(n);
    eq.push_back(e);
    want <= 1'b1;
    strobe(a, 1'b0);
  endtask
  task automatic exec(input logic [1:0] op);
    wr(FXE_A_OP_SEL, {30'h0, op});
    wr(FXE_A_EXECUTE, 32'h1);
    rd(FXE_A_EXECUTE, 32'h1, "busy");
    v = 32'h1;
    for (int k = 0; k < 300 && v !== 32'h0; k++) begin
      want <= 1'b0;
      strobe(FXE_A_EXECUTE, 1'b0);
      gap();
      v = reg_rdata;
    end
    if (v !== 32'h0) n_fail++;
    rd(FXE_A_EXECUTE, 32'h0, "done");
  endtask
  // results are judged one cycle after the read strobe
  always @(posedge clk) begin
    if (want_q) chk(nq.pop_front(), reg_rdata, eq.pop_front());
    want_q <= reg_rd && want;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    want = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    cyc = 0;
    seed = $urandom(32'h84B3);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(FXE_A_BUF_LEN, 32'(FXE_BUF_BYTES), "buf_len");
    rd(FXE_A_EXECUTE, 32'h0, "idle");
    wr(FXE_A_IRQ_EN, 32'h2);
    wr(FXE_A_FILE_SEL, 32'h0);
    exec(FXE_OP_OPEN);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_FILE_INVALID}, "st_absent");
    wr(FXE_A_FILE_SEL, 32'h1);
    wr(FXE_A_OPEN_MODE, {31'h0, FXE_MODE_READ});
    exec(FXE_OP_READ);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_NOT_OPENED}, "st_unopen");
    gap();
    chk("irq_err", {31'h0, irq}, 32'h1);
    wr(FXE_A_IRQ_CLR, 32'h3);
    gap();
    gap();
    chk("irq_clr", {31'h0, irq}, 32'h0);
    exec(FXE_OP_OPEN);
    rd(FXE_A_STATUS, 32'h0, "st_open");
    rd(FXE_A_FILE_SIZE, 32'd24, "size_rd");
    chk("irq_mask", {31'h0, irq}, 32'h0);
    exec(FXE_OP_READ);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_INVALID_PARAM}, "st_len0");
    wr(FXE_A_OFFSET, 32'h2);
    wr(FXE_A_LENGTH, 32'h4);
    exec(FXE_OP_READ);
    rd(FXE_A_RESULT, 32'h4, "res_rd");
    for (int i = 0; i < 4; i++) begin
      rd(FXE_A_BUF_BASE + 12'(4 * i), 32'(8'(66 + i) ^ 8'h5A), "buf");
    end
    rd(FXE_A_RESULT, 32'h4, "res_hold");
    exec(FXE_OP_WRITE);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_READ_ONLY}, "st_ro");
    exec(FXE_OP_CLOSE);
    rd(FXE_A_STATUS, 32'h0, "st_close");
    wr(FXE_A_FILE_SEL, 32'h2);
    wr(FXE_A_OPEN_MODE, {31'h0, FXE_MODE_WRITE});
    exec(FXE_OP_OPEN);
    rd(FXE_A_FILE_SIZE, 32'd128, "size_wr");
    wr(FXE_A_OFFSET, 32'd126);
    wr(FXE_A_LENGTH, 32'h3);
    exec(FXE_OP_WRITE);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_TOO_BIG}, "st_big");
    wr(FXE_A_OFFSET, 32'h5);
    wr(FXE_A_LENGTH, 32'h3);
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      wr(FXE_A_BUF_BASE + 12'(4 * i), {24'h0, d[i]});
    end
    exec(FXE_OP_WRITE);
    rd(FXE_A_STATUS, 32'h0, "st_wr");
    rd(FXE_A_RESULT, 32'h3, "res_wr");
    for (int i = 0; i < 3; i++) begin
      chk("stored", {24'h0, u_store.mem[133 + i]}, {24'h0, d[i]});
    end
    exec(FXE_OP_CLOSE);
    exec(FXE_OP_READ);
    rd(FXE_A_STATUS, {29'h0, FXE_ST_NOT_OPENED}, "st_closed");
    repeat (3) gap();
    results();
  end
endmodule
